// File: rtl/xpsc_ctrl.sv
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Code bit3 low selects input 0..7
// - Code bit3 high disables addressed amplifier
// - Update high, CE or load high: hold all (the code still writes a complete serial word to its input and switch register)
// - Update low: switch registers follow input registers
// - CE, load low, update high: addressed input transparent
// - All low: addressed input and switches transparent
// - Switch registers pass on update low, hold high (the code still writes the addressed slice from a complete serial word)
// - One switch register per amplifier
// - Serial mode: strobes high, select low
// - Serial words are 16 bits
// - Chain output is 16-stage delayed input
// - Chain output changes on serial clock fall
// - Select high: chain output holds last bit
// - Reset disables every amplifier
// - Input registers writable during shutdown
// - Two address bits select amplifier 0..3
// - Shutdown active high powers outputs down
module xpsc_ctrl (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        chip_en_n,
   input  wire logic        load_n,
   input  wire logic        update_n,
   input  wire logic        ser_clk,
   input  wire logic        ser_sel_n,
   input  wire logic        ser_din,
   input  wire logic        chan_code_off_bit,
   input  wire logic        chan_code_bit2,
   input  wire logic        chan_code_bit1,
   input  wire logic        chan_code_bit0,
   input  wire logic        amp_sel_hi,
   input  wire logic        amp_sel_lo,
   input  wire logic        power_down,
   output logic      [3:0]  amp_enable,
   output logic      [11:0] amp_input,
   output logic             chain_out
);
   logic [xpsc_pkg::PIN_W-1:0] raw;
   logic [xpsc_pkg::PIN_W-1:0] s1_r;
   logic [xpsc_pkg::PIN_W-1:0] s2_r;
   logic [xpsc_pkg::PIN_W-1:0] s3_r;
   logic [xpsc_pkg::PIN_W-1:0] pin_r;
   logic                       ce_n_f;
   logic                       ld_n_f;
   logic                       upd_n_f;
   logic                       sel_n_f;
   logic                       clk_f;
   logic                       pd_f;
   logic                       clk_prev_r;
   logic                       sel_prev_r;
   logic                       sclk_rise;
   logic                       sclk_fall;
   logic                       strobes_idle;
   logic                       ser_mode;
   logic                       frame_done;
   logic [xpsc_pkg::CNT_W-1:0] cnt_r;
   logic [15:0]                shift_r;
   logic [15:0]                word_r;
   logic [1:0]                 par_addr;
   logic [3:0]                 par_code;
   logic [1:0]                 ser_addr;
   logic [3:0]                 ser_code;
   logic [15:0]                in_r;
   logic [15:0]                sw_r;
   logic [3:0]                 amp_en_r;
   logic [11:0]                amp_in_r;
   logic                       chain_r;
   logic                       pd_eff;
   logic                       ctrl_r;
   logic                       ack_r;
   logic [31:0]                rdata_r;

   //////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: a bit moves only when stages two and three agree
   assign raw = {ser_din, ser_clk, ser_sel_n, update_n, load_n, chip_en_n, power_down,
                 amp_sel_hi, amp_sel_lo, chan_code_off_bit, chan_code_bit2,
                 chan_code_bit1, chan_code_bit0};

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r  <= xpsc_pkg::PIN_RST;
         s2_r  <= xpsc_pkg::PIN_RST;
         s3_r  <= xpsc_pkg::PIN_RST;
         pin_r <= xpsc_pkg::PIN_RST;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= (s3_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
      end
   end

   // Filtered pin levels
   assign ce_n_f   = pin_r[xpsc_pkg::P_CE];
   assign ld_n_f   = pin_r[xpsc_pkg::P_LD];
   assign upd_n_f  = pin_r[xpsc_pkg::P_UPD];
   assign sel_n_f  = pin_r[xpsc_pkg::P_SEL];
   assign clk_f    = pin_r[xpsc_pkg::P_CLK];
   assign pd_f     = pin_r[xpsc_pkg::P_PD];
   assign par_addr = pin_r[xpsc_pkg::P_AMP_LSB +: xpsc_pkg::SEL_W];
   assign par_code = pin_r[xpsc_pkg::P_CODE_LSB +: xpsc_pkg::CODE_W];

   //////////////////////////////////////////////////////////////////////////
   // Serial framing; parallel decode trusts select to stay high
   assign strobes_idle = ce_n_f & ld_n_f & upd_n_f;
   assign ser_mode     = strobes_idle & ~sel_n_f;
   assign sclk_rise    = clk_f & ~clk_prev_r;
   assign sclk_fall    = ~clk_f & clk_prev_r;
   // A short word is dropped rather than half applied
   assign frame_done   = sel_n_f & ~sel_prev_r & strobes_idle
                         & (cnt_r == xpsc_pkg::CNT_W'(xpsc_pkg::WORD_W));
   assign ser_addr     = shift_r[xpsc_pkg::WORD_AMP_LSB +: xpsc_pkg::SEL_W];
   assign ser_code     = shift_r[xpsc_pkg::CODE_W-1:0];

   // Edge history of serial clock and select
   always_ff @(posedge clk) begin
      if (reset) begin
         clk_prev_r <= 1'b0;
         sel_prev_r <= 1'b1;
      end else begin
         clk_prev_r <= clk_f;
         sel_prev_r <= sel_n_f;
      end
   end

   // Bit counter, saturates at one word; restarts when select falls
   always_ff @(posedge clk) begin
      if (reset || sel_n_f) begin
         cnt_r <= '0;
      end else if (ser_mode && sclk_rise && cnt_r != xpsc_pkg::CNT_W'(xpsc_pkg::WORD_W)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Sixteen-stage shift path, sampled on the serial clock rise
   always_ff @(posedge clk) begin
      if (reset) begin
         shift_r <= '0;
      end else if (ser_mode && sclk_rise) begin
         shift_r <= {shift_r[14:0], pin_r[xpsc_pkg::P_DIN]};
      end
   end

   // Chain output moves only on a fall inside a frame, else holds
   always_ff @(posedge clk) begin
      if (reset) begin
         chain_r <= 1'b0;
      end else if (!sel_n_f && sclk_fall) begin
         chain_r <= shift_r[15];
      end
   end

   // Last complete serial word, kept for software
   always_ff @(posedge clk) begin
      if (reset) begin
         word_r <= '0;
      end else if (frame_done) begin
         word_r <= shift_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Input register bank; shutdown does not block writes
   always_ff @(posedge clk) begin
      if (reset) begin
         in_r <= {xpsc_pkg::N_AMP{xpsc_pkg::CODE_OFF_RST}};
      end else if (frame_done) begin
         in_r[ser_addr*xpsc_pkg::CODE_W +: xpsc_pkg::CODE_W] <= ser_code;
      end else if (!ce_n_f && !ld_n_f) begin
         in_r[par_addr*xpsc_pkg::CODE_W +: xpsc_pkg::CODE_W] <= par_code;
      end
   end

   // Switch register bank, one slice per amplifier
   always_ff @(posedge clk) begin
      if (reset) begin
         sw_r <= {xpsc_pkg::N_AMP{xpsc_pkg::CODE_OFF_RST}};
      end else if (frame_done) begin
         sw_r[ser_addr*xpsc_pkg::CODE_W +: xpsc_pkg::CODE_W] <= ser_code;
      end else if (!upd_n_f) begin
         sw_r <= in_r;
      end
   end

   // Amplifier drive; shutdown gates enables but keeps codes
   assign pd_eff = pd_f | ctrl_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         amp_en_r <= '0;
         amp_in_r <= '0;
      end else begin
         for (int i = 0; i < xpsc_pkg::N_AMP; i++) begin
            amp_en_r[i] <= ~sw_r[i*xpsc_pkg::CODE_W + xpsc_pkg::OFF_BIT] & ~pd_eff;
            amp_in_r[i*3 +: 3] <= sw_r[i*xpsc_pkg::CODE_W +: 3];
         end
      end
   end

   assign amp_enable = amp_en_r;
   assign amp_input  = amp_in_r;
   assign chain_out  = chain_r;

   //////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then the request completes
   assign avs_waitrequest = ~ack_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   // Read data latched in the wait cycle; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= '0;
      end else if (avs_read && !ack_r) begin
         case (avs_address)
            xpsc_pkg::OFS_CTRL:   rdata_r <= {31'h00000000, ctrl_r};
            xpsc_pkg::OFS_STATUS: rdata_r <= {10'h000, pd_eff, ser_mode, amp_en_r, sw_r};
            xpsc_pkg::OFS_INREG:  rdata_r <= {16'h0000, in_r};
            xpsc_pkg::OFS_WORD:   rdata_r <= {16'h0000, word_r};
            default:              rdata_r <= 32'h00000000;
         endcase
      end
   end

   // Software power-down, ORed with the pin
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= xpsc_pkg::CTRL_RST;
      end else if (avs_write && ack_r && avs_address == xpsc_pkg::OFS_CTRL
                   && avs_byteenable[0]) begin
         ctrl_r <= avs_writedata[xpsc_pkg::CTRL_PD_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_word_end;
      $rose(sel_n_f) ##0 strobes_idle ##0 (cnt_r == xpsc_pkg::CNT_W'(xpsc_pkg::WORD_W));
   endsequence

   sequence s_fall_in_frame;
      !sel_n_f ##0 sclk_fall;
   endsequence

   a_code_selects: assert property (!sw_r[3] && !pd_eff |=> amp_en_r[0]
      && amp_in_r[2:0] == $past(sw_r[2:0])) else $error("amp0 input code wrong");
   a_off_disables: assert property (sw_r[7] |=> !amp_en_r[1])
      else $error("amp1 not disabled by off bit");
   a_hold_latched: assert property (upd_n_f && (ce_n_f || ld_n_f) && !frame_done
      |=> $stable(in_r) && $stable(sw_r)) else $error("registers moved while latched");
   a_switch_follow: assert property (!upd_n_f |=> sw_r == $past(in_r) ##1 amp_en_r[0]
      == (!$past(in_r[3], 2) && !$past(pd_eff))) else $error("switch not transparent");
   a_input_write: assert property (!ce_n_f && !ld_n_f |=> in_r[$past(par_addr)*4 +: 4]
      == $past(par_code)) else $error("addressed input not written");
   a_chain_fall: assert property (!sclk_fall || sel_n_f |=> $stable(chain_r))
      else $error("chain output moved off a falling edge");
   a_chain_shift: assert property (s_fall_in_frame |=> chain_r == $past(shift_r[15]))
      else $error("chain output not from last stage");
   a_frame_apply: assert property (s_word_end |=> sw_r[$past(ser_addr)*4 +: 4]
      == $past(ser_code) ##1 amp_in_r[$past(ser_addr, 2)*3 +: 3] == $past(ser_code[2:0], 2))
      else $error("serial word not applied");
   a_reset_off: assert property ($fell(reset) |-> amp_en_r == 4'h0
      && sw_r == {xpsc_pkg::N_AMP{xpsc_pkg::CODE_OFF_RST}})
      else $error("amplifiers not off after reset");
   a_shutdown_off: assert property (pd_eff |=> amp_en_r == 4'h0)
      else $error("amplifier on during shutdown");
endmodule // xpsc_ctrl
`default_nettype wire

// File: rtl/xpsc_pkg.sv
`default_nettype none
package xpsc_pkg;
   // Geometry of the switch
   localparam int N_AMP        = 4;
   localparam int CODE_W       = 4;
   localparam int OFF_BIT      = 3;
   localparam int SEL_W        = 2;
   localparam int WORD_W       = 16;
   localparam int WORD_AMP_LSB = 4;
   localparam int CNT_W        = 5;
   localparam logic [3:0] CODE_OFF_RST = 4'h8;

   // Register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_INREG  = 4'h8;
   localparam logic [3:0] OFS_WORD   = 4'hC;
   localparam int CTRL_PD_BIT = 0;
   localparam logic CTRL_RST  = 1'h0;

   // Positions of the pins in the synchronised pin vector
   localparam int PIN_W      = 13;
   localparam int P_CODE_LSB = 0;
   localparam int P_AMP_LSB  = 4;
   localparam int P_PD       = 6;
   localparam int P_CE       = 7;
   localparam int P_LD       = 8;
   localparam int P_UPD      = 9;
   localparam int P_SEL      = 10;
   localparam int P_CLK      = 11;
   localparam int P_DIN      = 12;
   // Strobes and serial select idle high
   localparam logic [12:0] PIN_RST = 13'h0780;
endpackage
`default_nettype wire

// File: tb/crosspoint_switch_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module crosspoint_switch_control_tb;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        rd_s = 1'b0;
   logic        wr_s = 1'b0;
   logic        ce_n = 1'b1;
   logic        ld_n = 1'b1;
   logic        up_n = 1'b1;
   logic        pd = 1'b1;
   logic        m_pd = 1'b0;
   logic [1:0]  asel = 2'h0;
   logic [3:0]  addr = 4'h0;
   logic [3:0]  code = 4'h0;
   logic [3:0]  m_in [4] = '{4{4'h8}};
   logic [3:0]  m_sw [4] = '{4{4'h8}};
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'hF;
   logic [31:0] rdata, rd;
   logic [3:0]  amp_enable;
   logic [11:0] amp_input;
   logic        wait_s, ser_clk, ser_sel_n, ser_din, chain_out;
   int          err_total = 0;
   int          n_tests = 0;

   // Design under test and the serial host
   xpsc_ctrl xpsc_ctrl_inst (.clk(clk), .reset(reset), .avs_address(addr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wait_s), .chip_en_n(ce_n), .load_n(ld_n), .update_n(up_n),
      .ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .ser_din(ser_din),
      .chan_code_off_bit(code[3]), .chan_code_bit2(code[2]), .chan_code_bit1(code[1]),
      .chan_code_bit0(code[0]), .amp_sel_hi(asel[1]), .amp_sel_lo(asel[0]),
      .power_down(pd), .amp_enable(amp_enable), .amp_input(amp_input),
      .chain_out(chain_out));
   xpsc_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_sel_n(ser_sel_n),
      .ser_din(ser_din));

   ////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Cuts a hang short; the whole run needs well under a third of this
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end

   task automatic close_out();
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Pins pass a three-stage filter, so every step is held a dozen clocks
   task automatic settle();
      repeat (12) @(posedge clk);
   endtask
   // Amplifier select is only compared where the amplifier drives
   task automatic chk_amps();
      for (int i = 0; i < 4; i++) begin
         chk(amp_enable[i], !m_pd && !m_sw[i][3]);
         if (!m_pd && !m_sw[i][3]) chk(amp_input[3*i+:3], m_sw[i][2:0]);
      end
   endtask
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      // No cycle count is assumed; a slave that never answers is left to the watchdog
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= w;
      rd_s <= !w;
      do begin
         @(posedge clk);
      end while (wait_s !== 1'b0);
      r = rdata;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask
   task automatic upd();
      @(posedge clk);
      up_n <= 1'b0;
      settle();
      up_n <= 1'b1;
      settle();
      m_sw = m_in;
   endtask
   task automatic par(input logic [1:0] a, input logic [3:0] c, input logic u);
      @(posedge clk);
      asel <= a;
      code <= c;
      settle();
      ce_n <= 1'b0;
      ld_n <= 1'b0;
      up_n <= !u;
      settle();
      ce_n <= 1'b1;
      ld_n <= 1'b1;
      up_n <= 1'b1;
      settle();
      m_in[a] = c;
      if (u) m_sw = m_in;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (2) @(posedge clk);
      chk(amp_enable, 4'h0);
      pd <= 1'b0;
      settle();
      chk_amps();
      av(1'b0, 4'h4, 32'h0, rd);
      chk(rd[15:0], 16'h8888);
   endtask
   task automatic t_par();
      for (int i = 0; i < 4; i++) par(2'(i), 4'(2 * i + 1), 1'b0);
      chk_amps();
      upd();
      chk_amps();
      for (int c = 0; c < 8; c++) begin
         par(2'h1, 4'(c), 1'b1);
         chk_amps();
      end
      par(2'h2, 4'hA, 1'b1);
      chk_amps();
   endtask
   // A lone load or CE strobe must not open any register
   task automatic t_hold();
      @(posedge clk);
      code <= 4'h3;
      ld_n <= 1'b0;
      settle();
      ld_n <= 1'b1;
      ce_n <= 1'b0;
      settle();
      ce_n <= 1'b1;
      upd();
      chk_amps();
   endtask
   task automatic t_ser();
      host.send(16'h0035, 16, 8);
      settle();
      m_in[3] = 4'h5;
      m_sw[3] = 4'h5;
      chk_amps();
      chk(chain_out, 1'b0);
      host.send(16'h8021, 16, 12);
      settle();
      m_in[2] = 4'h1;
      m_sw[2] = 4'h1;
      chk_amps();
      chk(chain_out, 1'b1);
      settle();
      chk(chain_out, 1'b1);
      host.send(16'h0030, 8, 8);
      settle();
      chk_amps();
      chk(chain_out, 1'b0);
   endtask
   task automatic t_pwr();
      @(posedge clk);
      pd <= 1'b1;
      settle();
      m_pd = 1'b1;
      chk_amps();
      par(2'h0, 4'h6, 1'b0);
      av(1'b0, 4'h8, 32'h0, rd);
      chk(rd[3:0], 4'h6);
      upd();
      pd <= 1'b0;
      settle();
      m_pd = 1'b0;
      chk_amps();
   endtask
   // Soft power-down, an unmapped read and the last serial word
   task automatic t_bus();
      av(1'b1, 4'h0, 32'h1, rd);
      settle();
      m_pd = 1'b1;
      chk_amps();
      // A clear with lane 0 masked must leave soft power-down set
      be <= 4'hE;
      av(1'b1, 4'h0, 32'h0, rd);
      be <= 4'hF;
      av(1'b0, 4'h0, 32'h0, rd);
      chk(rd[0], 1'b1);
      av(1'b0, 4'h2, 32'h0, rd);
      chk(rd, 32'h0);
      av(1'b0, 4'hC, 32'h0, rd);
      chk(rd[15:0], 16'h8021);
      av(1'b1, 4'h0, 32'h0, rd);
      av(1'b0, 4'h4, 32'h0, rd);
      chk(rd[15:0], {m_sw[3], m_sw[2], m_sw[1], m_sw[0]});
      chk(rd[21:16], {2'h0, !m_sw[3][3], !m_sw[2][3], !m_sw[1][3], !m_sw[0][3]});
      settle();
      m_pd = 1'b0;
      chk_amps();
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_par();
      t_hold();
      t_ser();
      t_pwr();
      t_bus();
      close_out();
   end
endmodule  // crosspoint_switch_control_tb
`default_nettype wire

// File: tb/xpsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the serial link; clock and data rest low between frames
module xpsc_host_model (
   input  wire logic clk,
   output var logic  ser_clk,
   output var logic  ser_sel_n,
   output var logic  ser_din
);
   initial begin
      ser_clk = 1'b0;
      ser_sel_n = 1'b1;
      ser_din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Sends the low n bits of w, highest first; hp of 8 or more keeps the
   // half period well inside what the pin filter can follow
   task automatic send(input logic [15:0] w, input int n, input int hp);
      @(posedge clk);
      ser_sel_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (hp) @(posedge clk);
         ser_din <= w[i];
         repeat (hp) @(posedge clk);
         ser_clk <= 1'b1;
         repeat (hp) @(posedge clk);
         ser_clk <= 1'b0;
      end
      repeat (hp) @(posedge clk);
      ser_sel_n <= 1'b1;
      ser_din <= 1'b0;
   endtask
endmodule  // xpsc_host_model
`default_nettype wire
